// ===== verilog/pmt_phy_pins.sv
// MAC-facing transmit, status, LED, interrupt and reset pins of the PHY
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

// Summary of operation
// - After reset the shared pin is a power-down input and becomes an interrupt output only when configured.
// - In power-down function a low level on the shared pin puts the device into power-down.
// - In interrupt function the pin is pulled low open-drain on an interrupt condition and left to the pull-up otherwise.
// - In MII mode the transmit clock runs at 25 MHz for 100 Mb/s and 2.5 MHz for 10 Mb/s.
// - The MII transmit clock is divided from the system clock with no tie to the reference clock and is unused in RMII mode.
// - Transmit enable is sampled on rising clock edges and data, four bits MII or two bits RMII, is valid only while it is high.
// - In MII full duplex the collision output is always low.
// - In MII half duplex collision is high only while both transmit and receive media are busy, and unused in RMII.
// - In MII mode carrier sense is high while either medium is busy, and unused in RMII.
// - The link/activity LED is on while the link is good and blinks while transmit or receive is active.
// - The transmit-error/speed-LED pin defaults to transmit error and a configuration bit turns it into the speed LED.
// - As speed LED the pin is on for a 100 Mb/s link and off for 10 Mb/s or no link.
// - The reset pin must be held low at least 25 us to start a device reset.
// - Each reset re-samples the straps and returns every configuration bit to its default.
module pmt_phy_pins #(
    parameter int BLINK_CYCLES = `PMT_BLINK_CYC,
    parameter int FIFO_DEPTH   = `PMT_FIFO_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       resetPinN,
    input  wire logic                       strapRmii,
    input  wire logic                       refClkPin,
    input  wire logic                       txEnPin,
    input  wire logic [`PMT_MII_W-1:0]      txDataPin,
    input  wire logic                       txErLedIn,
    output logic                            txErLedOut,
    output logic                            txErLedOe,
    input  wire logic                       intPinIn,
    output logic                            intPinOut,
    output logic                            intPinOe,
    output logic                            txClkOut,
    output logic                            colOut,
    output logic                            crsOut,
    output logic                            link_activity_led,
    output logic                            powerDown,
    output logic                            rmiiMode,
    output logic                            txOverflow,
    input  wire logic                       cfgWe,
    input  wire logic                       cfgIntMode,
    input  wire logic                       cfgSpeedLed,
    input  wire logic                       linkUp,
    input  wire logic                       link100,
    input  wire logic                       fullDuplex,
    input  wire logic                       rxActive,
    input  wire logic                       intEvent,
    output logic                            txOutValid,
    output logic [`PMT_FIFO_WIDTH-1:0]      txOutData,
    input  wire logic                       txOutReady
);
    localparam int BW = $clog2(BLINK_CYCLES + 1);
    localparam logic [11:0] RST_CYC   = 12'(`PMT_RST_CYC);
    localparam logic [4:0]  HALF_FAST = 5'(`PMT_HALF_FAST);
    localparam logic [4:0]  HALF_SLOW = 5'(`PMT_HALF_SLOW);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // elaboration check
    if (BLINK_CYCLES < 2 || `PMT_RST_CYC > 4095) begin : g_chk
        $error("pmt_phy_pins: blink count or reset count out of range");
    end

    typedef struct packed {
        logic [1:0]                rstPin;    // [0] first stage only
        logic [1:0]                intPin;
        logic [1:0]                refPin;
        logic [1:0]                enPin;
        logic [1:0]                erPin;
        logic [1:0]                strap;
        logic [1:0][3:0]           dataPin;
        logic                      refPrev;
        logic [11:0]               rstCnt;
        logic                      strapDone;
        pmt_pkg::pmt_if_t          ifMode;
        pmt_pkg::pmt_int_fn_t      intFn;
        logic                      speedLedEn;
        logic [4:0]                phase;
        logic                      txClk;
        logic                      txEnS;
        logic                      wrValid;
        logic [`PMT_FIFO_WIDTH-1:0] wrData;
        logic                      ovf;
        logic [BW-1:0]             blinkCnt;
        logic                      ledLink;
        logic                      col;
        logic                      crs;
        logic                      spdOut;
        logic                      spdOe;
        logic                      intOe;
        logic                      pwdn;
    } pmt_st_t;

    pmt_st_t s_q;
    pmt_st_t s_d;
    logic    pinReset;
    logic    coreRstN;
    logic    fifoInReady;
    logic    isMii;
    logic    txEvent;
    logic    fastMii;

    ////////////////////////////////////////////////////////////////////
    // reset pin held long enough acts as a full device reset
    assign pinReset = (s_q.rstCnt == RST_CYC);
    assign coreRstN = rst_n && !pinReset;
    assign isMii    = (s_q.ifMode == pmt_pkg::PMT_IF_MII);
    assign fastMii  = isMii && link100 && !s_q.pwdn;

    // data path sample point: own clock rise in MII, reference rise in RMII
    assign txEvent = isMii
        ? (!s_q.txClk && s_q.phase >= (link100 ? HALF_FAST : HALF_SLOW)
           - 5'h1 && !s_q.pwdn)
        : (s_q.refPin[1] && !s_q.refPrev);

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        // pin synchronisers
        s_d.rstPin  = {s_q.rstPin[0], resetPinN};
        s_d.intPin  = {s_q.intPin[0], intPinIn};
        s_d.refPin  = {s_q.refPin[0], refClkPin};
        s_d.enPin   = {s_q.enPin[0], txEnPin};
        s_d.erPin   = {s_q.erPin[0], txErLedIn};
        s_d.strap   = {s_q.strap[0], strapRmii};
        s_d.dataPin = {s_q.dataPin[0], txDataPin};
        s_d.refPrev = s_q.refPin[1];

        // low time of the reset pin, saturating at the trip count
        if (!s_q.rstPin[1]) begin
            s_d.rstCnt = pinReset ? s_q.rstCnt : s_q.rstCnt + 12'h1;
        end else begin
            s_d.rstCnt = 12'h0;
        end

        // strap re-scan on the first cycle out of reset
        if (!s_q.strapDone) begin
            s_d.strapDone = 1'b1;
            s_d.ifMode = s_q.strap[1] ? pmt_pkg::PMT_IF_RMII
                                      : pmt_pkg::PMT_IF_MII;
        end

        // configuration writes steer the shared pins
        if (cfgWe) begin
            s_d.intFn = cfgIntMode ? pmt_pkg::PMT_PIN_INT
                                   : pmt_pkg::PMT_PIN_PWDN;
            s_d.speedLedEn = cfgSpeedLed;
        end

        // power-down input and open-drain interrupt output
        s_d.pwdn  = (s_q.intFn == pmt_pkg::PMT_PIN_PWDN)
                    && !s_q.intPin[1];
        s_d.intOe = (s_q.intFn == pmt_pkg::PMT_PIN_INT)
                    && intEvent;

        // divider runs from reset in MII; RMII and power-down hold it at phase zero with the clock low
        if (!isMii || s_q.pwdn) begin
            s_d.phase = 5'h0;
            s_d.txClk = 1'b0;
        end else if (s_q.phase >= (link100 ? HALF_FAST : HALF_SLOW)
                     - 5'h1) begin
            s_d.phase = 5'h0;
            s_d.txClk = !s_q.txClk;
        end else begin
            s_d.phase = s_q.phase + 5'h1;
        end

        // transmit enable and data capture into the FIFO
        s_d.wrValid = 1'b0;
        if (txEvent) begin
            s_d.txEnS = s_q.enPin[1];
            if (s_q.enPin[1]) begin
                s_d.wrData = {s_q.erPin[1] && !s_q.speedLedEn,
                              isMii ? s_q.dataPin[1]
                                    : {2'b00, s_q.dataPin[1][1:0]}};
                if (fifoInReady) begin
                    s_d.wrValid = 1'b1;
                end else begin
                    s_d.ovf = 1'b1;
                end
            end
        end

        // collision and carrier sense
        s_d.col = isMii && !fullDuplex && s_q.txEnS && rxActive;
        s_d.crs = isMii && (s_q.txEnS || rxActive);

        // link LED: solid on link, blinking while traffic runs
        if (!linkUp) begin
            s_d.ledLink  = 1'b0;
            s_d.blinkCnt = '0;
        end else if (s_q.txEnS || rxActive) begin
            if (s_q.blinkCnt == BLINK_LAST) begin
                s_d.blinkCnt = '0;
                s_d.ledLink  = !s_q.ledLink;
            end else begin
                s_d.blinkCnt = s_q.blinkCnt + 1'b1;
            end
        end else begin
            s_d.ledLink  = 1'b1;
            s_d.blinkCnt = '0;
        end

        // shared error / speed LED pin
        s_d.spdOe  = s_q.speedLedEn;
        s_d.spdOut = s_q.speedLedEn && linkUp && link100;
    end

    ////////////////////////////////////////////////////////////////////
    // state register; pin reset keeps the synchronisers and its counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.rstPin <= 2'h3;
            s_q.intPin <= 2'h3;
            s_q.strap  <= s_d.strap;
        end else if (pinReset) begin
            s_q <= '0;
            s_q.rstPin  <= s_d.rstPin;
            s_q.intPin  <= s_d.intPin;
            s_q.refPin  <= s_d.refPin;
            s_q.enPin   <= s_d.enPin;
            s_q.erPin   <= s_d.erPin;
            s_q.strap   <= s_d.strap;
            s_q.dataPin <= s_d.dataPin;
            s_q.rstCnt  <= s_d.rstCnt;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit data FIFO
    pmt_fifo #(
        .WIDTH (`PMT_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (coreRstN),
        .inValid  (s_q.wrValid),
        .inData   (s_q.wrData),
        .inReady  (fifoInReady),
        .outValid (txOutValid),
        .outData  (txOutData),
        .outReady (txOutReady)
    );

    // outputs
    assign txClkOut          = s_q.txClk;
    assign colOut            = s_q.col;
    assign crsOut            = s_q.crs;
    assign link_activity_led = s_q.ledLink;
    assign powerDown         = s_q.pwdn;
    assign rmiiMode          = (s_q.ifMode == pmt_pkg::PMT_IF_RMII);
    assign txOverflow        = s_q.ovf;
    assign txErLedOut        = s_q.spdOut;
    assign txErLedOe         = s_q.spdOe;
    assign intPinOut         = 1'b0;
    assign intPinOe          = s_q.intOe;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_col_fdx_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        fullDuplex ##1 fullDuplex |-> !colOut)
        else $error("collision high in full duplex");

    a_col_half: assert property (
        @(posedge clk) disable iff (!coreRstN)
        ##1 colOut |-> $past(rxActive) && !$past(fullDuplex)
            && !rmiiMode)
        else $error("collision without both media busy");

    a_crs_follow: assert property (
        @(posedge clk) disable iff (!coreRstN)
        (isMii && rxActive) |=> crsOut)
        else $error("carrier sense missed receive activity");

    a_int_drive: assert property (
        @(posedge clk) disable iff (!coreRstN)
        (s_q.intFn == pmt_pkg::PMT_PIN_INT && intEvent) |=> intPinOe)
        else $error("interrupt pin not pulled low");

    a_pwdn_entry: assert property (
        @(posedge clk) disable iff (!coreRstN)
        (s_q.intFn == pmt_pkg::PMT_PIN_PWDN && !cfgWe) [*2]
        ##1 !s_q.intPin[1] |=> powerDown)
        else $error("power-down not entered");

    a_reset_default: assert property (
        @(posedge clk) disable iff (!rst_n)
        pinReset |=> !intPinOe && !txErLedOe
            && s_q.intFn == pmt_pkg::PMT_PIN_PWDN)
        else $error("defaults not restored by reset");

    a_spd_led: assert property (
        @(posedge clk) disable iff (!coreRstN)
        (s_q.speedLedEn && !cfgWe) ##1 !(linkUp && link100)
        |=> !txErLedOut)
        else $error("speed LED on without 100M link");

    a_txclk_fast: assert property (
        @(posedge clk) disable iff (!coreRstN)
        $rose(txClkOut) && fastMii ##1 fastMii |=> $fell(txClkOut))
        else $error("fast transmit clock half period wrong");

    a_tx_capture: assert property (
        @(posedge clk) disable iff (!coreRstN)
        txEvent && s_q.enPin[1] && fifoInReady |=> s_q.wrValid
            ##1 !s_q.wrValid || txEvent)
        else $error("enabled transmit data not captured");

endmodule
`default_nettype wire

// ===== verilog/pmt_map.svh
// constants for the MAC-facing pin logic of the PHY
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// system clock rate
`define PMT_CLK_KHZ 100000
// transmit clock rates for 100 Mb/s and 10 Mb/s
`define PMT_TXCLK_FAST_KHZ 25000
`define PMT_TXCLK_SLOW_KHZ 2500
// half periods of the transmit clock in system cycles
`define PMT_HALF_FAST (`PMT_CLK_KHZ / (2 * `PMT_TXCLK_FAST_KHZ))
`define PMT_HALF_SLOW (`PMT_CLK_KHZ / (2 * `PMT_TXCLK_SLOW_KHZ))
// least low time of the reset pin, rounded up to cycles
`define PMT_RST_MIN_US 25
`define PMT_RST_CYC ((`PMT_RST_MIN_US * `PMT_CLK_KHZ + 999) / 1000)
// half period of the activity blink
`define PMT_BLINK_MS 20
`define PMT_BLINK_CYC (`PMT_BLINK_MS * `PMT_CLK_KHZ)
// transmit data path
`define PMT_MII_W 4
`define PMT_RMII_W 2
`define PMT_FIFO_WIDTH 5
`define PMT_FIFO_DEPTH 32

`endif

// ===== verilog/pmt_pkg.sv
// types shared by the MAC-facing pin logic
package pmt_pkg;

    // function of the shared interrupt / power-down pin
    typedef enum logic {
        PMT_PIN_PWDN,
        PMT_PIN_INT
    } pmt_int_fn_t;

    // MAC interface flavour, taken from the strap
    typedef enum logic {
        PMT_IF_MII,
        PMT_IF_RMII
    } pmt_if_t;

endpackage

// ===== verilog/pmt_fifo.sv
// transmit data FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_fifo #(
    parameter int WIDTH = `PMT_FIFO_WIDTH,
    parameter int DEPTH = `PMT_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////
    // elaboration check
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("pmt_fifo: DEPTH must be a power of two and WIDTH >= 1");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
        logic                        valid;
        logic [WIDTH-1:0]            head;
    } pmt_fifo_st_t;

    pmt_fifo_st_t s_q;
    pmt_fifo_st_t s_d;
    logic         doWr;
    logic         doRd;

    ////////////////////////////////////////////////////////////////////
    // handshake terms and outputs
    assign inReady  = (s_q.count != (AW+1)'(DEPTH));
    assign outValid = s_q.valid;
    assign outData  = s_q.head;
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // next state
    always_comb begin
        s_d = s_q;
        if (doWr) begin
            s_d.mem[s_q.wrPtr] = inData;
            s_d.wrPtr          = s_q.wrPtr + 1'b1;
        end
        if (doRd) begin
            s_d.rdPtr = s_q.rdPtr + 1'b1;
        end
        case ({doWr, doRd})
            2'b10:   s_d.count = s_q.count + 1'b1;
            2'b01:   s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
        // head word and flag registered so the outputs leave a flop
        s_d.head  = s_d.mem[s_d.rdPtr];
        s_d.valid = (s_d.count != '0);
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// ===== tb/pmt_mac_model.sv
// behavioural MAC driving the transmit side of the PHY
`timescale 1ns/1ps
`default_nettype none

module pmt_mac_model (
    input  wire logic       txClk,
    input  wire logic       rmii,
    output logic            refClk,
    output logic            txEn,
    output logic [3:0]      txData,
    output logic            txEr
);

    // free-running reference oscillator, 125 ns period
    initial begin
        refClk = 1'b0;
        forever #62.5 refClk = ~refClk;
    end

    // lines idle before the first frame
    initial begin
        txEn = 1'b0;
        txData = 4'h5;
        txEr = 1'b0;
    end

    // one frame of n units counting up from first; rmii drives the upper
    // pair inverted so that it must be ignored; afterwards the released
    // data shows the inverse of its last value
    task automatic send(input int n, input logic [3:0] first);
        logic [3:0] d;
        d = first;
        for (int k = 0; k <= n; k++) begin
            if (rmii) begin
                @(negedge refClk);
            end else begin
                @(posedge txClk);
            end
            #1;
            txEn = k < n;
            txData = (k == n) ? ~txData : (rmii ? {~d[1:0], d[1:0]} : d);
            txEr = !rmii && k == 1;
            d = d + 4'h1;
        end
    endtask

endmodule
`default_nettype wire

// ===== tb/pmt_phy_pins_tb.sv
// self-checking bench for the MAC-facing pin logic
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_phy_pins_tb;

    logic       clk;
    logic       rst_n;
    logic       resetPinN;
    logic       strapRmii;
    logic       pwdnDrive;
    logic       cfgWe;
    logic       cfgIntMode;
    logic       cfgSpeedLed;
    logic       linkUp;
    logic       link100;
    logic       fullDuplex;
    logic       rxActive;
    logic       intEvent;
    logic       txOutReady;
    wire        refClk;
    wire        txEn;
    wire  [3:0] txData;
    wire        macTxEr;
    wire        txErLedIn;
    wire        txErLedOut;
    wire        txErLedOe;
    wire        intPinIn;
    wire        intPinOut;
    wire        intPinOe;
    wire        txClkOut;
    wire        colOut;
    wire        crsOut;
    wire        linkLed;
    wire        powerDown;
    wire        rmiiMode;
    wire        txOverflow;
    wire        txOutValid;
    wire  [4:0] txOutData;
    int         n_errors = 0;
    int         checks_done = 0;

    // shared pins: open drain with pull-up, and the tx-error/LED pin
    assign intPinIn = intPinOe ? intPinOut : pwdnDrive;
    assign txErLedIn = txErLedOe ? txErLedOut : macTxEr;

    pmt_phy_pins #(.BLINK_CYCLES(8), .FIFO_DEPTH(32)) i_pmt_phy_pins (
        .clk(clk), .rst_n(rst_n), .resetPinN(resetPinN),
        .strapRmii(strapRmii), .refClkPin(refClk), .txEnPin(txEn),
        .txDataPin(txData), .txErLedIn(txErLedIn),
        .txErLedOut(txErLedOut), .txErLedOe(txErLedOe),
        .intPinIn(intPinIn), .intPinOut(intPinOut), .intPinOe(intPinOe),
        .txClkOut(txClkOut), .colOut(colOut), .crsOut(crsOut),
        .link_activity_led(linkLed), .powerDown(powerDown),
        .rmiiMode(rmiiMode), .txOverflow(txOverflow), .cfgWe(cfgWe),
        .cfgIntMode(cfgIntMode), .cfgSpeedLed(cfgSpeedLed),
        .linkUp(linkUp), .link100(link100), .fullDuplex(fullDuplex),
        .rxActive(rxActive), .intEvent(intEvent),
        .txOutValid(txOutValid), .txOutData(txOutData),
        .txOutReady(txOutReady));

    pmt_mac_model i_pmt_mac_model (
        .txClk(txClkOut), .rmii(rmiiMode), .refClk(refClk),
        .txEn(txEn), .txData(txData), .txEr(macTxEr));

    ////////////////////////////////////////////////////////////////////
    // clock and helpers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle configuration write, then let the mode settle
    task automatic cfg(input logic im, input logic sl);
        @(posedge clk);
        cfgWe <= 1'b1;
        cfgIntMode <= im;
        cfgSpeedLed <= sl;
        @(posedge clk);
        cfgWe <= 1'b0;
        cyc(3);
    endtask

    // pop n words and compare them with the frame sent from first
    task automatic drain(input int n, input logic [3:0] first,
                         input logic rm);
        int k;
        int guard;
        logic [3:0] d;
        logic [15:0] e;
        k = 0;
        guard = 0;
        @(posedge clk);
        txOutReady <= 1'b1;
        while (k < n && guard < 500) begin
            @(negedge clk);
            guard++;
            if (txOutValid === 1'b1) begin
                d = first + 4'(k);
                e = rm ? {14'h0000, d[1:0]} : {11'h000, k == 1, d};
                chk("tx word", 16'(txOutData), e);
                k++;
            end
        end
        chk("word count", 16'(k), 16'(n));
        @(posedge clk);
        txOutReady <= 1'b0;
        cyc(2);
        chk("fifo empty", 16'(txOutValid), 16'h0000);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_pwdn();
        logic seen;
        chk("int oe", 16'(intPinOe), 16'h0000);
        chk("led oe", 16'(txErLedOe), 16'h0000);
        chk("rmii", 16'(rmiiMode), 16'h0000);
        chk("pwdn idle", 16'(powerDown), 16'h0000);
        @(posedge clk);
        pwdnDrive <= 1'b0;
        cyc(6);
        chk("pwdn on", 16'(powerDown), 16'h0001);
        seen = 1'b0;
        repeat (60) begin
            @(negedge clk);
            seen = seen | txClkOut;
        end
        chk("clk in pwdn", 16'(seen), 16'h0000);
        @(posedge clk);
        pwdnDrive <= 1'b1;
        cyc(6);
        chk("pwdn off", 16'(powerDown), 16'h0000);
        $display("test pwdn done");
    endtask

    task automatic t_txclk();
        time t0;
        int want;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            link100 <= s[0];
            cyc(60);
            @(posedge txClkOut);
            t0 = $time;
            @(posedge txClkOut);
            want = s ? `PMT_CLK_KHZ / `PMT_TXCLK_FAST_KHZ
                     : `PMT_CLK_KHZ / `PMT_TXCLK_SLOW_KHZ;
            chk("txclk period", 16'(($time - t0) / 10), 16'(want));
        end
        $display("test txclk done");
    endtask

    task automatic t_colcrs();
        @(posedge clk);
        txOutReady <= 1'b1;
        fork
            i_pmt_mac_model.send(16, 4'h0);
            begin
                cyc(20);
                chk("col full", 16'(colOut), 16'h0000);
                chk("crs tx", 16'(crsOut), 16'h0001);
                @(posedge clk) fullDuplex <= 1'b0;
                cyc(3);
                chk("col tx only", 16'(colOut), 16'h0000);
                @(posedge clk) rxActive <= 1'b1;
                cyc(3);
                chk("col both", 16'(colOut), 16'h0001);
            end
        join
        cyc(12);
        chk("col rx only", 16'(colOut), 16'h0000);
        chk("crs rx", 16'(crsOut), 16'h0001);
        @(posedge clk);
        rxActive <= 1'b0;
        fullDuplex <= 1'b1;
        txOutReady <= 1'b0;
        cyc(3);
        chk("crs idle", 16'(crsOut), 16'h0000);
        $display("test colcrs done");
    endtask

    // stalled FIFO takes 34 nibbles: 32 kept, the rest lost and flagged
    task automatic t_fifo();
        chk("no overflow", 16'(txOverflow), 16'h0000);
        i_pmt_mac_model.send(34, 4'h3);
        cyc(10);
        chk("overflow", 16'(txOverflow), 16'h0001);
        drain(32, 4'h3, 1'b0);
        $display("test fifo done");
    endtask

    task automatic t_led();
        int tog;
        logic prev;
        @(posedge clk) linkUp <= 1'b1;
        cyc(4);
        chk("led link", 16'(linkLed), 16'h0001);
        @(posedge clk) rxActive <= 1'b1;
        tog = 0;
        prev = linkLed;
        repeat (40) begin
            @(negedge clk);
            tog += (linkLed !== prev);
            prev = linkLed;
        end
        chk("led blinks", 16'(tog >= 3), 16'h0001);
        @(posedge clk) rxActive <= 1'b0;
        cyc(30);
        chk("led idle", 16'(linkLed), 16'h0001);
        cfg(1'b0, 1'b1);
        chk("led oe", 16'(txErLedOe), 16'h0001);
        chk("speed 100", 16'(txErLedOut), 16'h0001);
        @(posedge clk) link100 <= 1'b0;
        cyc(3);
        chk("speed 10", 16'(txErLedOut), 16'h0000);
        @(posedge clk) linkUp <= 1'b0;
        @(posedge clk) link100 <= 1'b1;
        cyc(3);
        chk("speed nolink", 16'(txErLedOut), 16'h0000);
        cfg(1'b0, 1'b0);
        chk("txer back", 16'(txErLedOe), 16'h0000);
        $display("test led done");
    endtask

    task automatic t_int();
        @(posedge clk) intEvent <= 1'b1;
        cyc(4);
        chk("int in pwdn fn", 16'(intPinOe), 16'h0000);
        cfg(1'b1, 1'b0);
        chk("int low", 16'(intPinOe), 16'h0001);
        chk("int pin level", 16'(intPinIn), 16'h0000);
        chk("no pwdn", 16'(powerDown), 16'h0000);
        @(posedge clk) intEvent <= 1'b0;
        cyc(4);
        chk("int released", 16'(intPinOe), 16'h0000);
        $display("test int done");
    endtask

    task automatic t_rstpin();
        @(posedge clk);
        intEvent <= 1'b1;
        strapRmii <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk) resetPinN <= 1'b0;
            repeat (s ? `PMT_RST_CYC + 20 : `PMT_RST_CYC - 100) @(posedge clk);
            resetPinN <= 1'b1;
            cyc(10);
            chk("strap", 16'(rmiiMode), 16'(s));
            chk("int mode", 16'(intPinOe), 16'(!s));
        end
        chk("overflow clr", 16'(txOverflow), 16'h0000);
        @(posedge clk) intEvent <= 1'b0;
        $display("test rstpin done");
    endtask

    task automatic t_rmii();
        cyc(20);
        chk("no txclk", 16'(txClkOut), 16'h0000);
        @(posedge clk) rxActive <= 1'b1;
        cyc(3);
        chk("crs rmii", 16'(crsOut), 16'h0000);
        @(posedge clk) rxActive <= 1'b0;
        i_pmt_mac_model.send(6, 4'h9);
        cyc(10);
        drain(6, 4'h9, 1'b1);
        $display("test rmii done");
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        resetPinN = 1'b1;
        strapRmii = 1'b0;
        pwdnDrive = 1'b1;
        cfgWe = 1'b0;
        cfgIntMode = 1'b0;
        cfgSpeedLed = 1'b0;
        linkUp = 1'b0;
        link100 = 1'b1;
        fullDuplex = 1'b1;
        rxActive = 1'b0;
        intEvent = 1'b0;
        txOutReady = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        t_pwdn();
        t_txclk();
        t_colcrs();
        t_fifo();
        t_led();
        t_int();
        t_rstpin();
        t_rmii();
        results();
    end

    initial begin
        #500_000;
        n_errors++;
        $display("watchdog expired");
        results();
    end

endmodule
`default_nettype wire
